// *** include/recorder_pkg.sv ***
`default_nettype none
package recorder_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_TRIG_ADDR = 8'h08;
    localparam logic [7:0] REG_TRIG_VAL = 8'h0c;
    localparam logic [7:0] REG_LEVEL = 8'h10;
    localparam logic [7:0] REG_DELAY = 8'h14;
    localparam logic [7:0] REG_COUNT = 8'h18;
    localparam logic [7:0] REG_PERIOD = 8'h1c;
    localparam logic [7:0] REG_UNIT = 8'h20;
    localparam logic [7:0] REG_REC_TIME = 8'h24;
    localparam logic [7:0] REG_RD_INDEX = 8'h28;
    localparam logic [7:0] REG_RD_DATA = 8'h2c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h30;
    localparam logic [7:0] REG_IRQ_MASK = 8'h34;
    // fields
    localparam int CTRL_ARM_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int IRQ_TRIG_BIT = 0;
    localparam int IRQ_DONE_BIT = 1;
    // sizes and reset values
    localparam logic [10:0] COUNT_MAX = 11'h400;
    localparam logic [10:0] COUNT_RST = 11'h400;
    localparam logic [15:0] PERIOD_RST = 16'h0001;
    localparam logic [15:0] LEVEL_RST = 16'h0000;
    localparam logic [15:0] DELAY_RST = 16'h0000;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [1:0] MASK_RST = 2'h0;
    // timing: unit ticks of 50 us, 50 ms and 3 s
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_MS_US = 50;
    localparam int TICK_S_MS = 50;
    localparam int TICK_MIN_S = 3;
    localparam int CYC_MS_UNIT = TICK_MS_US * 1000 / CLK_PERIOD_NS;
    localparam int CYC_S_UNIT = TICK_S_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CYC_MIN_UNIT = TICK_MIN_S * 1000 * (1000000 / CLK_PERIOD_NS);
    typedef enum logic [1:0] {MODE_IMM, MODE_POS, MODE_NEG} mode_type;
    typedef enum logic [1:0] {UNIT_MS, UNIT_S, UNIT_MIN} unit_type;
    typedef enum logic [2:0] {S_IDLE, S_WAIT, S_DLY, S_REC, S_DONE} state_type;
    typedef struct packed {
        mode_type mode;
        unit_type unit;
        logic [15:0] level;
        logic [15:0] delay;
        logic [10:0] count;
        logic [15:0] period;
        logic [15:0] trig_addr;
    } cfg_type;
endpackage
`default_nettype wire

// *** sim/signal_source.sv ***
`timescale 1ns/1ps
`default_nettype none
module signal_source
#(
    parameter logic [15:0] SEL_ADDR = 16'h0040
)
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // value asked for by the bench
    input wire logic [15:0] level_set,
    // recorder side
    input wire logic [15:0] var_addr,
    output logic [15:0] var_value,
    output logic [15:0] chan_value
);
    logic [15:0] sig_q;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            sig_q <= 16'h0000;
        end
        else
        begin
            sig_q <= level_set;
        end
    end

    // any other address shows a different variable
    assign var_value = (var_addr == SEL_ADDR) ? sig_q : ~sig_q;
    // recorded channel follows the signal with an offset
    assign chan_value = sig_q + 16'h1000;
endmodule // signal_source
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import recorder_pkg::*;
;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } row_type;

    logic clock, nrst, wr, rd, irq, busy;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, v;
    logic [15:0] var_addr, var_value, chan_value, level_set;
    int fails, num_checks, n, i;
    int unit_cyc [3] = '{1000, 20, 30};
    logic [31:0] pos_win [3] = '{32'h1000, 32'h1064, 32'h1005};
    row_type rows [19] = '{
        '{1'b0, REG_COUNT, 32'h0, 32'h400}, '{1'b0, REG_PERIOD, 32'h0, 32'h1},
        '{1'b0, REG_UNIT, 32'h0, 32'h0}, '{1'b0, REG_IRQ_MASK, 32'h0, 32'h0},
        '{1'b0, REG_STATUS, 32'h0, 32'h0}, '{1'b0, REG_CTRL, 32'h0, 32'h0},
        '{1'b1, REG_COUNT, 32'h5, 32'h5}, '{1'b1, REG_COUNT, 32'h0, 32'h1},
        '{1'b1, REG_COUNT, 32'h7ff, 32'h400}, '{1'b1, REG_PERIOD, 32'h0, 32'h1},
        '{1'b1, REG_PERIOD, 32'h3, 32'h3}, '{1'b1, REG_UNIT, 32'h2, 32'h2},
        '{1'b1, REG_UNIT, 32'h3, 32'h2}, '{1'b0, REG_REC_TIME, 32'h0, 32'hc00},
        '{1'b1, REG_TRIG_ADDR, 32'h1234, 32'h1234},
        '{1'b1, REG_LEVEL, 32'h80, 32'h80},
        '{1'b1, REG_DELAY, 32'hfffe, 32'hfffe}, '{1'b1, 8'h3c, 32'h5, 32'h0},
        '{1'b1, REG_CTRL, 32'h6, 32'h6}};

    triggered_signal_recorder #(.TICK_S_CYC(20), .TICK_MIN_CYC(30)) dut_u (
        .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .var_addr(var_addr), .var_value(var_value),
        .chan_value(chan_value), .irq(irq), .busy(busy));

    signal_source src_u (
        .clock(clock), .nrst(nrst), .level_set(level_set),
        .var_addr(var_addr), .var_value(var_value), .chan_value(chan_value));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task summarize;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask

    task rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task wait_idle(output int c);
        c = 0;
        do
        begin
            @(posedge clock);
            #1;
            c++;
        end
        while (busy !== 1'b0 && c < 3000);
        if (busy !== 1'b0)
            fails++;
    endtask

    task wait_trig;
        int k;
        k = 0;
        do
        begin
            rd_reg(REG_IRQ_STAT, v);
            k++;
        end
        while (v[IRQ_TRIG_BIT] !== 1'b1 && k < 200);
        if (v[IRQ_TRIG_BIT] !== 1'b1)
            fails++;
    endtask

    task read_sample(input int idx, output logic [31:0] d);
        wr_reg(REG_RD_INDEX, 32'(idx));
        rd_reg(REG_RD_DATA, d);
    endtask

    task edge_setup(input logic [31:0] cnt, input logic [31:0] dly);
        wr_reg(REG_UNIT, 32'h1);
        wr_reg(REG_PERIOD, 32'h1);
        wr_reg(REG_COUNT, cnt);
        wr_reg(REG_DELAY, dly);
        wr_reg(REG_LEVEL, 32'h64);
        wr_reg(REG_IRQ_STAT, 32'h3);
        level_set <= 16'h00c8;
        repeat (5) @(posedge clock);
    endtask

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        fails++;
        summarize();
    end

    initial
    begin
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        level_set = 16'h0000;
        fails = 0;
        num_checks = 0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        // register table: reset values, clamping, read-only, unmapped
        foreach (rows[r])
        begin
            if (rows[r].w)
                wr_reg(rows[r].a, rows[r].d);
            rd_reg(rows[r].a, v);
            check(v, rows[r].e);
        end
        check(32'(var_addr), 32'h1234);
        wr_reg(REG_TRIG_ADDR, 32'h40);
        // immediate capture of one sample in each period unit
        wr_reg(REG_COUNT, 32'h1);
        wr_reg(REG_PERIOD, 32'h1);
        wr_reg(REG_IRQ_MASK, 32'h3);
        for (i = 0; i < 3; i++)
        begin
            wr_reg(REG_UNIT, 32'(i));
            wr_reg(REG_CTRL, 32'h1);
            check(32'(busy), 32'h1);
            wait_idle(n);
            check(32'(n), 32'(unit_cyc[i]));
            rd_reg(REG_IRQ_STAT, v);
            check(v, 32'h3);
        end
        check(32'(irq), 32'h1);
        wr_reg(REG_IRQ_MASK, 32'h0);
        check(32'(irq), 32'h0);
        wr_reg(REG_IRQ_MASK, 32'h3);
        wr_reg(REG_IRQ_STAT, 32'h3);
        check(32'(irq), 32'h0);
        // rising edge, one pre-trigger sample
        edge_setup(32'h3, 32'h1);
        wr_reg(REG_CTRL, 32'h3);
        repeat (80) @(posedge clock);
        rd_reg(REG_STATUS, v);
        check(v, 32'h1);
        level_set <= 16'h0000;
        repeat (50) @(posedge clock);
        level_set <= 16'h0064;
        wait_trig();
        level_set <= 16'h0005;
        wait_idle(n);
        for (i = 0; i < 3; i++)
        begin
            read_sample(i, v);
            check(v, pos_win[i]);
        end
        rd_reg(REG_TRIG_VAL, v);
        check(v, 32'h5);
        // delay beyond the window: the trigger sample ends the capture
        edge_setup(32'h2, 32'h5);
        wr_reg(REG_CTRL, 32'h3);
        level_set <= 16'h0000;
        repeat (50) @(posedge clock);
        level_set <= 16'h0064;
        wait_trig();
        rd_reg(REG_STATUS, v);
        check(v, 32'h4);
        for (i = 0; i < 2; i++)
        begin
            read_sample(i, v);
            check(v, pos_win[i]);
        end
        // falling edge, storing starts two periods late
        edge_setup(32'h2, 32'hfffe);
        wr_reg(REG_CTRL, 32'h5);
        repeat (50) @(posedge clock);
        level_set <= 16'h0032;
        wait_trig();
        level_set <= 16'h0007;
        rd_reg(REG_STATUS, v);
        check(v, 32'h2);
        repeat (25) @(posedge clock);
        rd_reg(REG_STATUS, v);
        check(v, 32'h2);
        repeat (20) @(posedge clock);
        rd_reg(REG_STATUS, v);
        check(v, 32'h3);
        wait_idle(n);
        for (i = 0; i < 2; i++)
        begin
            read_sample(i, v);
            check(v, 32'h1007);
        end
        // re-arming restarts the full capture
        wr_reg(REG_COUNT, 32'h4);
        wr_reg(REG_CTRL, 32'h1);
        repeat (50) @(posedge clock);
        wr_reg(REG_CTRL, 32'h1);
        repeat (50) @(posedge clock);
        rd_reg(REG_STATUS, v);
        check(v, 32'h3);
        wait_idle(n);
        rd_reg(REG_STATUS, v);
        check(v, 32'h4);
        // reset in mid-capture clears outputs and settings
        wr_reg(REG_CTRL, 32'h1);
        check(32'(irq), 32'h1);
        @(posedge clock);
        nrst <= 1'b0;
        #1;
        check(32'(busy), 32'h0);
        check(32'(irq), 32'h0);
        check(32'(var_addr), 32'h0);
        check(rdata, 32'h0);
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        rd_reg(REG_COUNT, v);
        check(v, 32'h400);
        rd_reg(REG_STATUS, v);
        check(v, 32'h0);
        summarize();
    end
endmodule // tb_top
`default_nettype wire

// *** src/triggered_signal_recorder.sv ***
// Operation
// RULE1 - immediate mode records at once on arming
// RULE2 - positive edge triggers on rising to level
// RULE3 - negative edge triggers on falling to level
// RULE4 - edge trigger compares variable against level
// RULE5 - trigger variable independent of recorded channel
// RULE6 - samples kept locally, read after completion
// RULE7 - positive delay keeps pre-trigger samples
// RULE8 - negative delay starts storing after delay
// RULE9 - delay counted in sample periods
// RULE10 - sample count 1 to 1024, default 1024
// RULE11 - sample period 50 us to 3276.75 min
// RULE12 - period unit selects ms, s or min
// RULE13 - record time is period times count
// RULE14 - trigger source address readable back
// RULE15 - trigger variable value always readable
// RULE16 - re-arming discards capture, restarts detection
// RULE17 - completion flag after all samples stored
// RULE18 - edge needs previous sample opposite side
`timescale 1ns/1ps
`default_nettype none
module triggered_signal_recorder
    import recorder_pkg::*;
#(
    parameter int TICK_S_CYC = CYC_S_UNIT,
    parameter int TICK_MIN_CYC = CYC_MIN_UNIT
)
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // internal variables
    output logic [15:0] var_addr,
    input wire logic [15:0] var_value,
    input wire logic [15:0] chan_value,
    // status
    output logic irq,
    output logic busy
);

    function automatic logic [10:0] clamp_count(input logic [31:0] v);
        if (v == 32'h0)
        begin
            return 11'h001;
        end
        if (v > {21'h0, COUNT_MAX})
        begin
            return COUNT_MAX;
        end
        return v[10:0];
    endfunction

    function automatic logic [25:0] unit_len(input unit_type u);
        case (u)
            UNIT_MS: return 26'(CYC_MS_UNIT);
            UNIT_S: return 26'(TICK_S_CYC);
            UNIT_MIN: return 26'(TICK_MIN_CYC);
            default: return 26'(CYC_MS_UNIT);
        endcase
    endfunction

    function automatic logic edge_hit(input mode_type m,
        input logic [15:0] p, input logic [15:0] c, input logic [15:0] l);
        case (m)
            MODE_POS: return $signed(p) < $signed(l) && $signed(c) >= $signed(l);
            MODE_NEG: return $signed(p) > $signed(l) && $signed(c) <= $signed(l);
            default: return 1'b0;
        endcase
    endfunction

    cfg_type cfg_q, cfg_d;
    logic [1:0] stat_q, stat_d, mask_q, mask_d;
    logic [9:0] idx_q, idx_d;
    logic [31:0] rdata_q, rdata_d;
    logic [25:0] pres_q, pres_d;
    logic [15:0] per_q, per_d;
    state_type state_q, state_d;
    logic [9:0] wptr_q, wptr_d, start_q, start_d;
    logic [10:0] left_q, left_d;
    logic [15:0] dly_q, dly_d, prev_q, prev_d;
    logic have_prev_q, have_prev_d;
    logic [15:0] mem [0:1023];
    logic [26:0] rec_time;
    logic [1:0] wmode;
    logic arm, tick, unit_tick, mem_we, ev_trig, ev_done;
    logic [10:0] pre;

    assign wmode = wdata[CTRL_MODE_LSB+1:CTRL_MODE_LSB];
    assign arm = wr && addr == REG_CTRL && wdata[CTRL_ARM_BIT]; // RULE16
    assign var_addr = cfg_q.trig_addr; // RULE5 RULE14
    assign rec_time = {11'h0, cfg_q.period} * {16'h0, cfg_q.count}; // RULE13
    assign rdata = rdata_q;
    assign irq = |(stat_q & mask_q);
    assign busy = state_q == S_WAIT || state_q == S_DLY || state_q == S_REC;

    // register file
    always_comb
    begin
        cfg_d = cfg_q;
        mask_d = mask_q;
        idx_d = idx_q;
        rdata_d = 32'h0;
        stat_d = stat_q | {ev_done, ev_trig};
        if (wr)
        begin
            case (addr)
                REG_CTRL: cfg_d.mode = mode_type'(wmode);
                REG_TRIG_ADDR: cfg_d.trig_addr = wdata[15:0]; // RULE14
                REG_LEVEL: cfg_d.level = wdata[15:0]; // RULE4
                REG_DELAY: cfg_d.delay = wdata[15:0]; // RULE9
                REG_COUNT: cfg_d.count = clamp_count(wdata); // RULE10
                REG_PERIOD: cfg_d.period = wdata[15:0] == 16'h0 ?
                    16'h1 : wdata[15:0]; // RULE11
                REG_UNIT: cfg_d.unit = wdata[1:0] == 2'h3 ?
                    cfg_q.unit : unit_type'(wdata[1:0]); // RULE12
                REG_RD_INDEX: idx_d = wdata[9:0];
                REG_IRQ_STAT: stat_d = (stat_q & ~wdata[1:0])
                    | {ev_done, ev_trig};
                REG_IRQ_MASK: mask_d = wdata[1:0];
                default: ;
            endcase
        end
        if (rd)
        begin
            case (addr)
                REG_CTRL: rdata_d = {29'h0, cfg_q.mode, 1'b0};
                REG_STATUS: rdata_d = {29'h0, state_q};
                REG_TRIG_ADDR: rdata_d = {16'h0, cfg_q.trig_addr}; // RULE14
                REG_TRIG_VAL: rdata_d = {16'h0, var_value}; // RULE15
                REG_LEVEL: rdata_d = {16'h0, cfg_q.level};
                REG_DELAY: rdata_d = {16'h0, cfg_q.delay};
                REG_COUNT: rdata_d = {21'h0, cfg_q.count};
                REG_PERIOD: rdata_d = {16'h0, cfg_q.period};
                REG_UNIT: rdata_d = {30'h0, cfg_q.unit};
                REG_REC_TIME: rdata_d = {5'h0, rec_time}; // RULE13
                REG_RD_INDEX: rdata_d = {22'h0, idx_q};
                REG_RD_DATA: rdata_d = state_q == S_DONE ?
                    {16'h0, mem[start_q + idx_q]} : 32'h0; // RULE6
                REG_IRQ_STAT: rdata_d = {30'h0, stat_q};
                REG_IRQ_MASK: rdata_d = {30'h0, mask_q};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_q <= {MODE_IMM, UNIT_MS, LEVEL_RST, DELAY_RST, COUNT_RST,
                PERIOD_RST, ADDR_RST};
            mask_q <= MASK_RST;
            stat_q <= 2'h0;
            idx_q <= 10'h0;
            rdata_q <= 32'h0;
        end
        else
        begin
            cfg_q <= cfg_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            idx_q <= idx_d;
            rdata_q <= rdata_d;
        end
    end

    // sample timebase
    assign unit_tick = pres_q == unit_len(cfg_q.unit) - 26'h1;
    assign tick = busy && unit_tick && per_q == cfg_q.period - 16'h1;

    always_comb
    begin
        pres_d = pres_q;
        per_d = per_q;
        if (arm || !busy)
        begin
            pres_d = 26'h0;
            per_d = 16'h0;
        end
        else if (unit_tick)
        begin
            pres_d = 26'h0; // RULE11 RULE12
            per_d = tick ? 16'h0 : per_q + 16'h1;
        end
        else
        begin
            pres_d = pres_q + 26'h1;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pres_q <= 26'h0;
            per_q <= 16'h0;
        end
        else
        begin
            pres_q <= pres_d;
            per_q <= per_d;
        end
    end

    // recorder
    always_comb
    begin
        state_d = state_q;
        wptr_d = wptr_q;
        start_d = start_q;
        left_d = left_q;
        dly_d = dly_q;
        prev_d = prev_q;
        have_prev_d = have_prev_q;
        mem_we = 1'b0;
        ev_trig = 1'b0;
        ev_done = 1'b0;
        pre = $signed(cfg_q.delay) >= $signed({5'h0, cfg_q.count})
            ? cfg_q.count - 11'h1 : cfg_q.delay[10:0];
        if (arm)
        begin
            wptr_d = 10'h0; // RULE16
            have_prev_d = 1'b0;
            dly_d = 16'h0;
            left_d = cfg_q.count;
            state_d = S_WAIT;
            if (wmode == MODE_IMM)
            begin
                state_d = S_REC; // RULE1
                ev_trig = 1'b1;
            end
        end
        else
        begin
            case (state_q)
                S_WAIT:
                begin
                    if (tick)
                    begin
                        mem_we = 1'b1; // RULE7
                        wptr_d = wptr_q + 10'h1;
                        prev_d = var_value;
                        have_prev_d = 1'b1;
                        if (have_prev_q && edge_hit(cfg_q.mode, prev_q,
                            var_value, cfg_q.level)) // RULE2 RULE3 RULE18
                        begin
                            ev_trig = 1'b1;
                            if (cfg_q.delay[15])
                            begin
                                state_d = S_DLY; // RULE8
                                dly_d = 16'h0 - cfg_q.delay;
                            end
                            else if (cfg_q.count - pre == 11'h1)
                            begin
                                state_d = S_DONE; // RULE7
                                ev_done = 1'b1;
                                start_d = wptr_q + 10'h1 - cfg_q.count[9:0];
                            end
                            else
                            begin
                                state_d = S_REC;
                                left_d = cfg_q.count - pre - 11'h1;
                            end
                        end
                    end
                end
                S_DLY:
                begin
                    if (tick)
                    begin
                        dly_d = dly_q - 16'h1; // RULE8 RULE9
                        if (dly_q == 16'h1)
                        begin
                            state_d = S_REC;
                            left_d = cfg_q.count;
                        end
                    end
                end
                S_REC:
                begin
                    if (tick)
                    begin
                        mem_we = 1'b1; // RULE6
                        wptr_d = wptr_q + 10'h1;
                        left_d = left_q - 11'h1;
                        if (left_q == 11'h1)
                        begin
                            state_d = S_DONE; // RULE17
                            ev_done = 1'b1;
                            start_d = wptr_q + 10'h1 - cfg_q.count[9:0];
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= S_IDLE;
            wptr_q <= 10'h0;
            start_q <= 10'h0;
            left_q <= 11'h0;
            dly_q <= 16'h0;
            prev_q <= 16'h0;
            have_prev_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            wptr_q <= wptr_d;
            start_q <= start_d;
            left_q <= left_d;
            dly_q <= dly_d;
            prev_q <= prev_d;
            have_prev_q <= have_prev_d;
        end
    end

    always_ff @(posedge clock)
    begin
        if (mem_we)
        begin
            mem[wptr_q] <= chan_value;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    imm_start_a: assert property (arm && wmode == MODE_IMM |=> // RULE1
        state_q == S_REC && left_q == $past(cfg_q.count))
        else $error("immediate arm did not start recording");
    pos_edge_a: assert property (state_q == S_WAIT && tick && !arm // RULE2
        && have_prev_q && cfg_q.mode == MODE_POS
        && $signed(prev_q) < $signed(cfg_q.level)
        && $signed(var_value) >= $signed(cfg_q.level)
        |=> state_q != S_WAIT && stat_q[IRQ_TRIG_BIT])
        else $error("rising edge missed");
    neg_edge_a: assert property (state_q == S_WAIT && tick && !arm // RULE3
        && have_prev_q && cfg_q.mode == MODE_NEG
        && $signed(prev_q) > $signed(cfg_q.level)
        && $signed(var_value) <= $signed(cfg_q.level)
        |=> state_q != S_WAIT)
        else $error("falling edge missed");
    first_sample_a: assert property (state_q == S_WAIT && !arm // RULE18
        && !have_prev_q |=> state_q == S_WAIT)
        else $error("trigger without previous sample");
    trig_addr_a: assert property (rd && addr == REG_TRIG_ADDR // RULE14
        |=> rdata == {16'h0, $past(cfg_q.trig_addr)})
        else $error("trigger address readback wrong");
    trig_val_a: assert property (rd && addr == REG_TRIG_VAL // RULE15
        |=> rdata == {16'h0, $past(var_value)})
        else $error("trigger value readback wrong");
    rearm_clear_a: assert property (arm |=> wptr_q == 10'h0 // RULE16
        && state_q inside {S_WAIT, S_REC})
        else $error("re-arm did not restart");
    done_flag_a: assert property (state_q == S_REC && tick && !arm // RULE17
        && left_q == 11'h1 |=> state_q == S_DONE && stat_q[IRQ_DONE_BIT])
        else $error("completion not flagged");
    neg_delay_a: assert property (state_q == S_WAIT && ev_trig // RULE8
        && !arm && cfg_q.delay[15] |=> state_q == S_DLY ##1 !mem_we)
        else $error("negative delay stored early");
    count_range_a: assert property (wr && addr == REG_COUNT // RULE10
        |=> cfg_q.count >= 11'h1 && cfg_q.count <= COUNT_MAX)
        else $error("sample count out of range");
    read_gate_a: assert property (rd && addr == REG_RD_DATA // RULE6
        && state_q != S_DONE |=> rdata == 32'h0)
        else $error("data readable before completion");

    imm_done_c: cover property (arm && wmode == MODE_IMM ##[1:1000]
        state_q == S_DONE);
    edge_trig_c: cover property (state_q == S_WAIT && ev_trig);
    delay_path_c: cover property (state_q == S_DLY ##[1:1000]
        state_q == S_REC);

endmodule // triggered_signal_recorder
`default_nettype wire
